// ===== hdl/drive_restart_ctrl.sv
// Auto restart, trip retry and override input control of a drive
`include "drive_defs.svh"
module drive_restart_ctrl #(
    parameter int TICK_CYCLES = `TICK_CYC,
    parameter int RETRY_TICKS = `RETRY_TICKS,
    parameter int DB_TICKS = `DEBOUNCE_TICKS
) (
    input wire logic I_MCLK,
    input wire logic I_RSTN,
    input wire logic [2:0] I_AUTO_RESTART_SETTING,
    input wire logic I_RUN_CMD,
    input wire logic I_TRIP,
    input wire logic I_FAULT_RESET,
    input wire logic [4:0] I_DI_FUNC,
    input wire logic I_OVR_POLARITY,
    input wire logic I_OVR_LATCH,
    input wire logic I_OVR_IN,
    output logic O_RUN,
    output logic O_RESTART,
    output logic O_FAULT,
    output logic O_LOCKOUT,
    output logic [2:0] O_ATTEMPTS,
    output logic O_OVERRIDE
);
    drive_pkg::run_state_type state_r;
    drive_pkg::run_state_type state_nxt;
    logic [`TICK_W-1:0] tick_cnt_r;
    logic tick;
    logic [`WAIT_W-1:0] wait_cnt_r;
    logic wait_done;
    logic [2:0] attempt_cnt_r;
    logic auto_pend_r;
    logic run_cmd_d_r;
    logic start_req;
    logic retry_mode;
    logic retry_left;
    logic ovr_sel;
    logic ovr_level;
    logic ovr_req;
    logic [`DB_W-1:0] arm_cnt_r;
    logic ovr_arm;

    // ------------------------------------------------------------
    // Millisecond tick
    // ------------------------------------------------------------
    assign tick = (tick_cnt_r == `TICK_W'(TICK_CYCLES - 1));

    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            tick_cnt_r <= '0;
        end else if (tick) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick_cnt_r + `TICK_W'(1);
        end
    end

    // ------------------------------------------------------------
    // Start request
    // ------------------------------------------------------------
    assign retry_mode = (I_AUTO_RESTART_SETTING != `AR_MANUAL) &&
        (I_AUTO_RESTART_SETTING <= `AR_MAX_TRY);
    assign retry_left = attempt_cnt_r < I_AUTO_RESTART_SETTING;
    assign start_req = I_RUN_CMD && !run_cmd_d_r;

    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            run_cmd_d_r <= 1'b0;
        end else begin
            run_cmd_d_r <= I_RUN_CMD;
        end
    end

    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            auto_pend_r <= 1'b1;
        end else if (state_r == drive_pkg::ST_STOP) begin
            auto_pend_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Run state machine
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            drive_pkg::ST_STOP: begin
                if (start_req || (auto_pend_r &&
                    I_AUTO_RESTART_SETTING == `AR_AUTO)) begin
                    state_nxt = drive_pkg::ST_RUN;
                end
            end
            drive_pkg::ST_RUN: begin
                if (I_TRIP) begin
                    if (retry_mode && retry_left) begin
                        state_nxt = drive_pkg::ST_WAIT;
                    end else if (retry_mode) begin
                        state_nxt = drive_pkg::ST_LOCK;
                    end else begin
                        state_nxt = drive_pkg::ST_STOP;
                    end
                end else if (!I_RUN_CMD &&
                    I_AUTO_RESTART_SETTING != `AR_AUTO) begin
                    state_nxt = drive_pkg::ST_STOP;
                end
            end
            drive_pkg::ST_WAIT: begin
                if (wait_done) begin
                    state_nxt = drive_pkg::ST_RUN;
                end
            end
            drive_pkg::ST_LOCK: begin
                if (I_FAULT_RESET) begin
                    state_nxt = drive_pkg::ST_STOP;
                end
            end
        endcase
    end

    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            state_r <= drive_pkg::ST_STOP;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // Retry spacing
    // ------------------------------------------------------------
    assign wait_done = tick && (wait_cnt_r == `WAIT_W'(RETRY_TICKS - 1));

    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            wait_cnt_r <= '0;
        end else if (state_r != drive_pkg::ST_WAIT || wait_done) begin
            wait_cnt_r <= '0;
        end else if (tick) begin
            wait_cnt_r <= wait_cnt_r + `WAIT_W'(1);
        end
    end

    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            attempt_cnt_r <= `CNT_ZERO;
        end else if (state_r == drive_pkg::ST_WAIT && wait_done) begin
            attempt_cnt_r <= attempt_cnt_r + `CNT_ONE;
        end
    end

    // ------------------------------------------------------------
    // Drive outputs
    // ------------------------------------------------------------
    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_RUN <= 1'b0;
            O_RESTART <= 1'b0;
            O_LOCKOUT <= 1'b0;
            O_ATTEMPTS <= `CNT_ZERO;
        end else begin
            O_RUN <= state_nxt == drive_pkg::ST_RUN;
            O_RESTART <= state_r == drive_pkg::ST_WAIT && wait_done;
            O_LOCKOUT <= state_nxt == drive_pkg::ST_LOCK;
            O_ATTEMPTS <= attempt_cnt_r;
        end
    end

    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_FAULT <= 1'b0;
        end else if (state_r == drive_pkg::ST_RUN && I_TRIP &&
            !(retry_mode && retry_left)) begin
            O_FAULT <= 1'b1;
        end else if (I_FAULT_RESET) begin
            O_FAULT <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Override input
    // ------------------------------------------------------------
    // filter before evaluation
    input_debounce #(
        .DB_TICKS(DB_TICKS)
    ) u_ovr_db (
        .i_clk(I_MCLK),
        .i_rst_n(I_RSTN),
        .i_tick(tick),
        .i_raw(I_OVR_IN),
        .o_level(ovr_level)
    );

    assign ovr_sel = (I_DI_FUNC >= `DI_OVR_FIRST) &&
        (I_DI_FUNC <= `DI_OVR_LAST);
    assign ovr_req = I_OVR_POLARITY ? ovr_level : !ovr_level;
    assign ovr_arm = (arm_cnt_r == `DB_W'(DB_TICKS));

    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            arm_cnt_r <= '0;
        end else if (tick && !ovr_arm) begin
            arm_cnt_r <= arm_cnt_r + `DB_W'(1);
        end
    end

    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_OVERRIDE <= 1'b0;
        end else if (!ovr_sel || !ovr_arm) begin
            O_OVERRIDE <= 1'b0;
        end else if (I_OVR_LATCH) begin
            O_OVERRIDE <= O_OVERRIDE || ovr_req;
        end else begin
            O_OVERRIDE <= ovr_req;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RSTN);

    property p_auto_start;
        state_r == drive_pkg::ST_STOP && auto_pend_r &&
            I_AUTO_RESTART_SETTING == `AR_AUTO |=> O_RUN;
    endproperty
    a_auto_start: assert property (p_auto_start)
        else $error("automatic start missing after reset");
    property p_retry_enter;
        state_r == drive_pkg::ST_RUN && I_TRIP && retry_mode &&
            retry_left |=> state_r == drive_pkg::ST_WAIT && !O_RUN;
    endproperty
    a_retry_enter: assert property (p_retry_enter)
        else $error("trip with retries left did not wait");
    property p_restart_limit;
        O_RESTART |-> O_RUN && attempt_cnt_r <= `AR_MAX_TRY &&
            $past(state_r) == drive_pkg::ST_WAIT;
    endproperty
    a_restart_limit: assert property (p_restart_limit)
        else $error("restart outside wait or over limit");
    property p_lockout;
        state_r == drive_pkg::ST_RUN && I_TRIP && retry_mode &&
            !retry_left |=> O_LOCKOUT && O_FAULT ##1
            (O_FAULT || $past(I_FAULT_RESET));
    endproperty
    a_lockout: assert property (p_lockout)
        else $error("final failed attempt did not lock out");
    property p_lock_hold;
        state_r == drive_pkg::ST_LOCK && !I_FAULT_RESET |=>
            state_r == drive_pkg::ST_LOCK;
    endproperty
    a_lock_hold: assert property (p_lock_hold)
        else $error("lockout left without fault reset");
    property p_count_kept;
        I_FAULT_RESET |=> attempt_cnt_r >= $past(attempt_cnt_r);
    endproperty
    a_count_kept: assert property (p_count_kept)
        else $error("attempt count cleared by fault reset");
    property p_ovr_off;
        (!ovr_sel || !ovr_arm) |=> !O_OVERRIDE;
    endproperty
    a_ovr_off: assert property (p_ovr_off)
        else $error("override active without override function");
    property p_nc_open;
        ovr_arm && ovr_sel && !I_OVR_POLARITY && !ovr_level |=> O_OVERRIDE;
    endproperty
    a_nc_open: assert property (p_nc_open)
        else $error("open contact did not request override");
    property p_no_closed;
        ovr_arm && ovr_sel && I_OVR_POLARITY && ovr_level |=> O_OVERRIDE;
    endproperty
    a_no_closed: assert property (p_no_closed)
        else $error("closed contact did not request override");
    property p_momentary;
        ovr_sel && !I_OVR_LATCH && !ovr_req |=> !O_OVERRIDE;
    endproperty
    a_momentary: assert property (p_momentary)
        else $error("override held after input released");
    property p_latched;
        O_OVERRIDE && ovr_sel && I_OVR_LATCH |=> O_OVERRIDE;
    endproperty
    a_latched: assert property (p_latched)
        else $error("latched override dropped while enabled");
    c_retry: cover property (O_RESTART);
    c_lock: cover property ($rose(O_LOCKOUT));
    c_ovr_latch: cover property (O_OVERRIDE && I_OVR_LATCH && !ovr_req);
endmodule : drive_restart_ctrl

// ===== inc/drive_defs.svh
// Constants for the drive restart and override control block
// What this block does
// - Automatic option starts drive after reset
// - Retry setting: up to 5 restarts, 20 s apart
// - Count attempts; final failure locks out with fault
// - Attempt count cleared only by power removal
// - Override settings act only for override functions
// - Polarity 0: override while contact open
// - Polarity 1: override while contact closed
// - Latch 0: override follows corrected input
// - Latch 1: pulse latches override until disabled
`ifndef DRIVE_DEFS_SVH
`define DRIVE_DEFS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_HZ 20000000
`define TICK_US 1000
`define TICK_CYC (`CLK_HZ / 1000000 * `TICK_US)
`define RETRY_S 20
`define RETRY_TICKS (`RETRY_S * 1000000 / `TICK_US)
`define DEBOUNCE_MS 10
`define DEBOUNCE_TICKS (`DEBOUNCE_MS * 1000 / `TICK_US)
`define TICK_W 15
`define WAIT_W 15
`define DB_W 4

// ----------------------------------------------------------------
// Settings
// ----------------------------------------------------------------
`define AR_MANUAL 3'h0
`define AR_MAX_TRY 3'h5
`define AR_AUTO 3'h7
`define CNT_ZERO 3'h0
`define CNT_ONE 3'h1
`define DI_OVR_FIRST 5'h0F
`define DI_OVR_LAST 5'h12

`endif

// ===== inc/drive_pkg.sv
// Types for the drive restart and override control block
package drive_pkg;
    typedef enum logic [1:0] {
        ST_STOP = 2'b00,
        ST_RUN = 2'b01,
        ST_WAIT = 2'b10,
        ST_LOCK = 2'b11
    } run_state_type;
endpackage : drive_pkg

// ===== hdl/input_debounce.sv
// Two-stage synchroniser and tick-based debounce filter
`include "drive_defs.svh"
module input_debounce #(
    parameter int DB_TICKS = `DEBOUNCE_TICKS
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_tick,
    input wire logic i_raw,
    output logic o_level
);
    logic sync1_r;
    logic sync2_r;
    logic [`DB_W-1:0] db_cnt_r;
    logic db_done;

    // ------------------------------------------------------------
    // Synchroniser
    // ------------------------------------------------------------
    // two flop sync
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= i_raw;
            sync2_r <= sync1_r;
        end
    end

    // ------------------------------------------------------------
    // Debounce
    // ------------------------------------------------------------
    assign db_done = i_tick && (db_cnt_r == `DB_W'(DB_TICKS - 1));

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            db_cnt_r <= '0;
            o_level <= 1'b0;
        end else if (sync2_r == o_level) begin
            db_cnt_r <= '0;
        end else if (db_done) begin
            db_cnt_r <= '0;
            o_level <= sync2_r;
        end else if (i_tick) begin
            db_cnt_r <= db_cnt_r + `DB_W'(1);
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    property p_db_stable;
        !db_done |=> $stable(o_level);
    endproperty
    a_db_stable: assert property (p_db_stable)
        else $error("debounced level moved before filter time");

    c_db_change: cover property ($changed(o_level));
endmodule : input_debounce

// ===== testbench/contact_switch.sv
// Bouncing contact switch model for the override input pin
module contact_switch #(
    parameter int BOUNCE = 6
) (
    input wire logic i_clk,
    input wire logic i_cmd,
    output logic o_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Contact with chatter after every change of command
    // ------------------------------------------------------------
    logic last_r = 1'b0;
    logic pin_r = 1'b0;
    int left_r = 0;
    assign o_pin = pin_r;
    always @(posedge i_clk) begin
        if (i_cmd !== last_r) begin
            last_r <= i_cmd;
            left_r <= BOUNCE;
            pin_r <= ~pin_r;
        end else if (left_r > 0) begin
            left_r <= left_r - 1;
            pin_r <= ~pin_r;
        end else begin
            pin_r <= last_r;
        end
    end
endmodule : contact_switch

// ===== testbench/tb_top.sv
// Self-checking bench for the drive restart and override block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] ar_set = 3'h0;
    logic run_cmd = 1'b0;
    logic trip = 1'b0;
    logic fault_rst = 1'b0;
    logic [4:0] di_func = 5'h00;
    logic ovr_pol = 1'b0;
    logic ovr_latch = 1'b0;
    logic sw_cmd = 1'b0;
    logic ovr_pin;
    logic run, restart, fault, lockout, override;
    logic [2:0] attempts;
    int bad_count = 0;
    int samples_checked = 0;
    localparam int TB_TICK = 4;
    localparam int TB_RETRY = 3;
    localparam int TB_DB = 2;
    always #25 mclk = ~mclk;
    // ------------------------------------------------------------
    // Design and contact
    // ------------------------------------------------------------
    drive_restart_ctrl #(.TICK_CYCLES(TB_TICK), .RETRY_TICKS(TB_RETRY),
        .DB_TICKS(TB_DB))
    dut (
        .I_MCLK(mclk), .I_RSTN(rst_n), .I_AUTO_RESTART_SETTING(ar_set),
        .I_RUN_CMD(run_cmd), .I_TRIP(trip), .I_FAULT_RESET(fault_rst),
        .I_DI_FUNC(di_func), .I_OVR_POLARITY(ovr_pol),
        .I_OVR_LATCH(ovr_latch), .I_OVR_IN(ovr_pin), .O_RUN(run),
        .O_RESTART(restart), .O_FAULT(fault), .O_LOCKOUT(lockout),
        .O_ATTEMPTS(attempts), .O_OVERRIDE(override)
    );
    contact_switch sw (.i_clk(mclk), .i_cmd(sw_cmd), .o_pin(ovr_pin));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task step(input int n);
        repeat (n) @(posedge mclk);
        #5;
    endtask : step
    task check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task power_cycle();
        rst_n = 1'b0;
        step(8);
        rst_n = 1'b1;
    endtask : power_cycle
    task pulse_trip();
        trip = 1'b1;
        step(1);
        trip = 1'b0;
    endtask : pulse_trip
    task trip_restart(input logic [2:0] exp_cnt);
        int n;
        pulse_trip();
        step(1);
        n = 1;
        check(run, 1'b0);
        while (restart !== 1'b1 && n < 40) begin
            step(1);
            n++;
        end
        check(n > (TB_RETRY - 1) * TB_TICK, 1'b1);
        check(n <= TB_RETRY * TB_TICK, 1'b1);
        check(run, 1'b1);
        step(1);
        check(restart, 1'b0);
        check(attempts, exp_cnt);
    endtask : trip_restart
    task wait_ovr(input logic exp);
        int n;
        n = 0;
        while (override !== exp && n < 40) begin
            step(1);
            n++;
        end
        check(override, exp);
    endtask : wait_ovr
    task end_sim();
        $display("Counts: %0d mismatches in %0d checks", bad_count,
                 samples_checked);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        ar_set = 3'h7;
        power_cycle();
        step(3);
        check(run, 1'b1);
        ar_set = 3'h2;
        power_cycle();
        step(3);
        check(run, 1'b0);
        run_cmd = 1'b1;
        step(3);
        check(run, 1'b1);
        trip_restart(3'h1);
        trip_restart(3'h2);
        pulse_trip();
        step(2);
        check({run, fault, lockout}, 3'h3);
        fault_rst = 1'b1;
        step(1);
        fault_rst = 1'b0;
        step(2);
        check({fault, lockout}, 2'h0);
        check(attempts, 3'h2);
        run_cmd = 1'b0;
        step(1);
        run_cmd = 1'b1;
        step(3);
        check(run, 1'b1);
        pulse_trip();
        step(2);
        check(lockout, 1'b1);
        run_cmd = 1'b0;
        ar_set = 3'h0;
        di_func = 5'h0F;
        power_cycle();
        step(2);
        check(attempts, 3'h0);
        check(override, 1'b0);
        for (int f = 5'h0F; f <= 5'h12; f++) begin
            di_func = f[4:0];
            for (int p = 0; p < 2; p++) begin
                ovr_pol = p[0];
                sw_cmd = p[0];
                wait_ovr(1'b1);
                sw_cmd = ~p[0];
                wait_ovr(1'b0);
            end
        end
        ovr_pol = 1'b0;
        sw_cmd = 1'b0;
        di_func = 5'h0E;
        step(40);
        check(override, 1'b0);
        di_func = 5'h13;
        step(40);
        check(override, 1'b0);
        di_func = 5'h10;
        ovr_pol = 1'b1;
        ovr_latch = 1'b1;
        wait_ovr(1'b0);
        sw_cmd = 1'b1;
        step(2);
        sw_cmd = 1'b0;
        step(40);
        check(override, 1'b0);
        sw_cmd = 1'b1;
        wait_ovr(1'b1);
        sw_cmd = 1'b0;
        step(40);
        check(override, 1'b1);
        di_func = 5'h0E;
        step(2);
        check(override, 1'b0);
        ar_set = 3'h6;
        run_cmd = 1'b1;
        step(3);
        check(run, 1'b1);
        pulse_trip();
        step(2);
        check({run, fault, lockout}, 3'h2);
        check(attempts, 3'h0);
        end_sim();
    end
    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    initial begin
        #1000000;
        bad_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        end_sim();
    end
endmodule : tb_top
